// ==== hsdc_pkg.sv ====
package hsdc_pkg;

    // Bus widths
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 11;     // Queue counts in 2048-byte buffer units
    localparam int PORTS  = 4;
    localparam int MAC_DEPTH = 16;  // Indirect MAC registers per port

    // Size of one queue buffer unit
    localparam int BUF_UNIT_BYTES = 2048;

    // Queue size registers hold the count in steps of eight buffers
    localparam int QREG_SHIFT = 3;

    // Default transmit queue sizes
    localparam logic [CNT_W-1:0] TXQ_SIZE_BASE  = 11'd640;
    localparam logic [CNT_W-1:0] TXQ_SIZE_SMALL = 11'd512;
    localparam logic [CNT_W-1:0] TXQ_SIZE_LARGE = 11'd768;
    // Transmit thresholds, equal in all profiles
    localparam logic [CNT_W-1:0] TXQ_HI_MARK    = 11'd384;
    localparam logic [CNT_W-1:0] TXQ_LO_MARK    = 11'd192;
    // Default receive queue sizes
    localparam logic [CNT_W-1:0] RXQ_SIZE_BASE  = 11'd1408;
    localparam logic [CNT_W-1:0] RXQ_SIZE_LARGE = 11'd1536;
    localparam logic [CNT_W-1:0] RXQ_SIZE_SMALL = 11'd1280;
    // Receive low thresholds
    localparam logic [CNT_W-1:0] RXQ_LO_BASE    = 11'd480;
    localparam logic [CNT_W-1:0] RXQ_LO_WIDE    = 11'd512;
    localparam logic [CNT_W-1:0] RXQ_LO_NARROW  = 11'd384;
    // Receive high thresholds
    localparam logic [CNT_W-1:0] RXQ_HI_BASE    = 11'd960;
    localparam logic [CNT_W-1:0] RXQ_HI_WIDE    = 11'd1024;
    localparam logic [CNT_W-1:0] RXQ_HI_NARROW  = 11'd768;

    // Profile codes
    localparam logic [1:0] PROF_BASE   = 2'h0;
    localparam logic [1:0] PROF_WIDE   = 2'h1;
    localparam logic [1:0] PROF_NARROW = 2'h2;

    // Section bounds of the register space
    localparam logic [ADDR_W-1:0] GLOBAL_END = 10'h03f;
    localparam logic [ADDR_W-1:0] ARB_END    = 10'h07f;
    localparam logic [ADDR_W-1:0] BERT_END   = 10'h0bf;
    localparam logic [ADDR_W-1:0] RSVD_BASE  = 10'h3c0;
    localparam logic [PORTS-1:0][ADDR_W-1:0] SER_BASE = {10'h300, 10'h240, 10'h180, 10'h0c0};
    localparam logic [PORTS-1:0][ADDR_W-1:0] SER_END  = {10'h37f, 10'h2bf, 10'h1ff, 10'h13f};
    localparam logic [PORTS-1:0][ADDR_W-1:0] ETH_BASE = {10'h380, 10'h2c0, 10'h200, 10'h140};
    localparam logic [PORTS-1:0][ADDR_W-1:0] ETH_END  = {10'h3bf, 10'h2ff, 10'h23f, 10'h17f};

    // Own registers inside the global and arbiter sections
    localparam logic [ADDR_W-1:0] STRAP_STAT_OFF = 10'h030;
    localparam logic [ADDR_W-1:0] LATCH_STAT_OFF = 10'h031;
    localparam logic [ADDR_W-1:0] ARB_LAST_OFF   = 10'h047;
    // Indirect MAC access window inside each Ethernet section
    localparam logic [ADDR_W-1:0] MAC_IDX_OFF  = 10'h000;
    localparam logic [ADDR_W-1:0] MAC_DATA_OFF = 10'h001;
    localparam logic [ADDR_W-1:0] MAC_CMD_OFF  = 10'h002;
    localparam int MAC_CMD_WR_BIT = 0;
    localparam int MAC_CMD_RD_BIT = 1;

    // Register space sections
    typedef enum logic [2:0] {SECT_GLOBAL, SECT_ARB, SECT_BERT, SECT_SER, SECT_ETH, SECT_RSVD}
        hsdc_sect_t;

    // Board strap pins
    typedef struct packed {
        logic       strap_config_enable;
        logic [1:0] profile_select;
        logic       reduced_interface_select;
        logic       serial_role_select;
        logic [PORTS-1:0] port_duplex_select;
        logic       laps_encap_enable;
        logic       scrambler_disable;
        logic       bit_order_reverse;
    } hsdc_strap_t;

    // Modes handed to the datapath
    typedef struct packed {
        logic       hw_mode_active;
        logic       rmii_mode;
        logic       serial_is_dce;
        logic [PORTS-1:0] full_duplex;
        logic       laps_enable;
        logic       scrambler_enable;
        logic       lsb_first;
    } hsdc_mode_t;

    // Queue sizes and thresholds of one port
    typedef struct packed {
        logic [CNT_W-1:0] tx_queue_size;
        logic [CNT_W-1:0] tx_queue_high_mark;
        logic [CNT_W-1:0] tx_queue_low_mark;
        logic [CNT_W-1:0] rx_queue_size;
        logic [CNT_W-1:0] rx_queue_high_mark;
        logic [CNT_W-1:0] rx_queue_low_mark;
    } hsdc_qcfg_t;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } hsdc_bus_t;

    // Decoded address
    typedef struct packed {
        hsdc_sect_t        sect;
        logic [1:0]        port;
        logic [ADDR_W-1:0] off;
    } hsdc_dec_t;

endpackage : hsdc_pkg

// ==== hsdc_strap_board.sv ====
`timescale 1ns/10ps
`default_nettype none

// Board strap pins as the board presents them to the device
module hsdc_strap_board (
    // Clock
    input  wire logic                  clk,
    // Level chosen by the bench
    input  wire hsdc_pkg::hsdc_strap_t setting,
    // Pins towards the device
    output hsdc_pkg::hsdc_strap_t      straps
);
    // Pins settle one cycle after the bench picks them, like a slow board net
    always_ff @(posedge clk) begin
        straps <= setting;
    end
endmodule : hsdc_strap_board

`default_nettype wire

// ==== hsdc_top.sv ====
// Added by the designer: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Strap high enables hardware mode defaults
// - Two profile straps pick default set
// - Transmit queue sizes per profile and port
// - Transmit high mark 384 on every port
// - Transmit low mark 192 on every port
// - Receive queue sizes per profile and port
// - Receive low marks per profile and port
// - Receive high marks per profile and port
// - Counts are in 2048-byte buffer units
// - Interface strap picks MII or RMII
// - Role strap high DCE, low DTE
// - Duplex strap per port: low half
// - Encapsulation strap high enables LAPS both ways
// - Scrambler strap low enables x43+1 scrambling
// - Bit order strap high sends LSB first
// - Ten address lines, 64-byte sections, serial port sections 128 bytes
// - Decode global, arbiter, BERT, port, reserved ranges
// - MAC registers reached only by indirect access
// - Latched status set by event, read clears
module hsdc_top (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    // Board straps, asynchronous
    input  wire hsdc_pkg::hsdc_strap_t   straps,
    // Register port
    input  wire hsdc_pkg::hsdc_bus_t     bus_req,
    output logic [hsdc_pkg::DATA_W-1:0]  bus_rdata,
    // Configuration to the datapath
    output hsdc_pkg::hsdc_mode_t         mode_out,
    output hsdc_pkg::hsdc_qcfg_t [hsdc_pkg::PORTS-1:0] qcfg_out
);

    // Whole state of the block
    typedef struct packed {
        hsdc_pkg::hsdc_strap_t sync1;     // First synchroniser stage
        hsdc_pkg::hsdc_strap_t sync2;     // Second synchroniser stage
        hsdc_pkg::hsdc_strap_t cap;       // Straps caught during reset
        hsdc_pkg::hsdc_mode_t  mode;      // Decoded modes
        hsdc_pkg::hsdc_qcfg_t [hsdc_pkg::PORTS-1:0] q;  // Queue setup
        logic [hsdc_pkg::DATA_W-1:0] rdata;             // Read answer
        logic                  chg_seen;  // Strap moved after reset
        logic                  bad_seen;  // Access to a reserved spot
        logic [hsdc_pkg::PORTS-1:0][3:0] mac_idx;       // Indirect index
        logic [hsdc_pkg::PORTS-1:0][hsdc_pkg::DATA_W-1:0] mac_data;
        logic [hsdc_pkg::PORTS-1:0][hsdc_pkg::MAC_DEPTH-1:0][hsdc_pkg::DATA_W-1:0] mac;
    } hsdc_st_t;

    hsdc_st_t st_ff;                      // Registered state
    hsdc_st_t nxt_st;                     // Next state

    // Defaults of one port under one profile
    function automatic hsdc_pkg::hsdc_qcfg_t hsdc_default(input logic [1:0] prof,
                                                          input logic [1:0] port);
        hsdc_pkg::hsdc_qcfg_t c;
        c.tx_queue_high_mark = hsdc_pkg::TXQ_HI_MARK;
        c.tx_queue_low_mark  = hsdc_pkg::TXQ_LO_MARK;
        c.tx_queue_size      = hsdc_pkg::TXQ_SIZE_BASE;
        c.rx_queue_size      = hsdc_pkg::RXQ_SIZE_BASE;
        c.rx_queue_low_mark  = hsdc_pkg::RXQ_LO_BASE;
        c.rx_queue_high_mark = hsdc_pkg::RXQ_HI_BASE;
        // Unused code 11 falls back to the base profile
        if (prof == hsdc_pkg::PROF_WIDE) begin
            c.rx_queue_low_mark  = hsdc_pkg::RXQ_LO_WIDE;
            c.rx_queue_high_mark = hsdc_pkg::RXQ_HI_WIDE;
            if (port != 2'h3) begin
                c.tx_queue_size = hsdc_pkg::TXQ_SIZE_SMALL;
                c.rx_queue_size = hsdc_pkg::RXQ_SIZE_LARGE;
            end
        end else if (prof == hsdc_pkg::PROF_NARROW) begin
            if (port < 2'h2) begin
                c.tx_queue_size      = hsdc_pkg::TXQ_SIZE_LARGE;
                c.rx_queue_size      = hsdc_pkg::RXQ_SIZE_SMALL;
                c.rx_queue_low_mark  = hsdc_pkg::RXQ_LO_NARROW;
                c.rx_queue_high_mark = hsdc_pkg::RXQ_HI_NARROW;
            end
        end
        return c;
    endfunction : hsdc_default

    // Sort an address into its section and offset
    function automatic hsdc_pkg::hsdc_dec_t hsdc_decode(input logic [hsdc_pkg::ADDR_W-1:0] a);
        hsdc_pkg::hsdc_dec_t d;
        d.sect = hsdc_pkg::SECT_RSVD;
        d.port = 2'h0;
        d.off  = a;
        if (a <= hsdc_pkg::GLOBAL_END) begin
            d.sect = hsdc_pkg::SECT_GLOBAL;
        end else if (a <= hsdc_pkg::ARB_END) begin
            d.sect = hsdc_pkg::SECT_ARB;
        end else if (a <= hsdc_pkg::BERT_END) begin
            d.sect = hsdc_pkg::SECT_BERT;
        end else if (a < hsdc_pkg::RSVD_BASE) begin
            for (int p = 0; p < hsdc_pkg::PORTS; p++) begin
                if (a >= hsdc_pkg::SER_BASE[p] && a <= hsdc_pkg::SER_END[p]) begin
                    d.sect = hsdc_pkg::SECT_SER;
                    d.port = p[1:0];
                    d.off  = a - hsdc_pkg::SER_BASE[p];
                end
                if (a >= hsdc_pkg::ETH_BASE[p] && a <= hsdc_pkg::ETH_END[p]) begin
                    d.sect = hsdc_pkg::SECT_ETH;
                    d.port = p[1:0];
                    d.off  = a - hsdc_pkg::ETH_BASE[p];
                end
            end
        end
        return d;
    endfunction : hsdc_decode

    // Decoded request and event terms
    hsdc_pkg::hsdc_dec_t dec;             // Current address, decoded
    logic                acc;             // Any access this cycle
    logic                bad_acc;         // Access into a reserved spot
    logic                latch_rd;        // Read of the latched status
    logic [hsdc_pkg::DATA_W-1:0] rd_val;  // Value a read returns

    // Address decode and read mux
    always_comb begin
        dec      = hsdc_decode(bus_req.addr);
        acc      = bus_req.wr | bus_req.rd;
        bad_acc  = 1'b0;
        rd_val   = '0;
        latch_rd = bus_req.rd && dec.sect == hsdc_pkg::SECT_GLOBAL
                   && dec.off == hsdc_pkg::LATCH_STAT_OFF;
        unique case (dec.sect)
            hsdc_pkg::SECT_GLOBAL: begin
                // Strap view, then latched events
                if (dec.off == hsdc_pkg::STRAP_STAT_OFF) begin
                    rd_val = {st_ff.mode.hw_mode_active, st_ff.cap.profile_select,
                              st_ff.mode.rmii_mode, st_ff.mode.serial_is_dce,
                              st_ff.mode.laps_enable, st_ff.mode.scrambler_enable,
                              st_ff.mode.lsb_first};
                end else if (dec.off == hsdc_pkg::LATCH_STAT_OFF) begin
                    rd_val = {6'h00, st_ff.bad_seen, st_ff.chg_seen};
                end else begin
                    bad_acc = acc;
                end
            end
            hsdc_pkg::SECT_ARB: begin
                // Even offsets receive, odd transmit, two per port
                if (dec.off <= hsdc_pkg::ARB_LAST_OFF) begin
                    if (dec.off[0]) begin
                        rd_val = st_ff.q[dec.off[2:1]].tx_queue_size[hsdc_pkg::CNT_W-1:hsdc_pkg::QREG_SHIFT];
                    end else begin
                        rd_val = st_ff.q[dec.off[2:1]].rx_queue_size[hsdc_pkg::CNT_W-1:hsdc_pkg::QREG_SHIFT];
                    end
                end else begin
                    bad_acc = acc;
                end
            end
            hsdc_pkg::SECT_BERT, hsdc_pkg::SECT_SER: begin
                // Served by other blocks; reads zero here
                rd_val = '0;
            end
            hsdc_pkg::SECT_ETH: begin
                // Only the indirect window is visible
                if (dec.off == hsdc_pkg::MAC_IDX_OFF) begin
                    rd_val = {4'h0, st_ff.mac_idx[dec.port]};
                end else if (dec.off == hsdc_pkg::MAC_DATA_OFF) begin
                    rd_val = st_ff.mac_data[dec.port];
                end else if (dec.off != hsdc_pkg::MAC_CMD_OFF) begin
                    bad_acc = acc;
                end
            end
            hsdc_pkg::SECT_RSVD: begin
                bad_acc = acc;
            end
        endcase
    end

    // Next state
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.sync1 = straps;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.rdata = '0;
        // Modes follow the caught straps, off outside hardware mode
        nxt_st.mode.hw_mode_active   = st_ff.cap.strap_config_enable;
        nxt_st.mode.rmii_mode        = st_ff.cap.strap_config_enable
                                       & st_ff.cap.reduced_interface_select;
        nxt_st.mode.serial_is_dce    = st_ff.cap.strap_config_enable
                                       & st_ff.cap.serial_role_select;
        nxt_st.mode.full_duplex      = st_ff.cap.strap_config_enable
                                       ? st_ff.cap.port_duplex_select : '0;
        nxt_st.mode.laps_enable      = st_ff.cap.strap_config_enable
                                       & st_ff.cap.laps_encap_enable;
        nxt_st.mode.scrambler_enable = st_ff.cap.strap_config_enable
                                       & ~st_ff.cap.scrambler_disable;
        nxt_st.mode.lsb_first        = st_ff.cap.strap_config_enable
                                       & st_ff.cap.bit_order_reverse;
        if (sys_rst) begin
            // Catch straps and load defaults while reset lasts
            nxt_st.cap      = st_ff.sync2;
            nxt_st.mode     = '0;
            nxt_st.chg_seen = 1'b0;
            nxt_st.bad_seen = 1'b0;
            nxt_st.mac_idx  = '0;
            nxt_st.mac_data = '0;
            nxt_st.mac      = '0;
            for (int p = 0; p < hsdc_pkg::PORTS; p++) begin
                // Software mode starts from empty queues
                nxt_st.q[p] = st_ff.sync2.strap_config_enable
                              ? hsdc_default(st_ff.sync2.profile_select, p[1:0])
                              : '0;
            end
        end else begin
            // Set wins over the clearing read
            nxt_st.chg_seen = (st_ff.chg_seen & ~latch_rd)
                              | (st_ff.sync2 != st_ff.cap);
            nxt_st.bad_seen = (st_ff.bad_seen & ~latch_rd) | bad_acc;
            if (bus_req.rd) begin
                nxt_st.rdata = rd_val;
            end
            if (bus_req.wr) begin
                // Reserved spots drop writes; the access still sets bad_seen
                if (dec.sect == hsdc_pkg::SECT_ARB && dec.off <= hsdc_pkg::ARB_LAST_OFF) begin
                    if (dec.off[0]) begin
                        nxt_st.q[dec.off[2:1]].tx_queue_size = {bus_req.wdata, 3'h0};
                    end else begin
                        nxt_st.q[dec.off[2:1]].rx_queue_size = {bus_req.wdata, 3'h0};
                    end
                end
                if (dec.sect == hsdc_pkg::SECT_ETH) begin
                    // MAC array reached through index, data and command
                    if (dec.off == hsdc_pkg::MAC_IDX_OFF) begin
                        nxt_st.mac_idx[dec.port] = bus_req.wdata[3:0];
                    end else if (dec.off == hsdc_pkg::MAC_DATA_OFF) begin
                        nxt_st.mac_data[dec.port] = bus_req.wdata;
                    end else if (dec.off == hsdc_pkg::MAC_CMD_OFF) begin
                        // Write takes priority when both bits are set
                        if (bus_req.wdata[hsdc_pkg::MAC_CMD_WR_BIT]) begin
                            nxt_st.mac[dec.port][st_ff.mac_idx[dec.port]] =
                                st_ff.mac_data[dec.port];
                        end else if (bus_req.wdata[hsdc_pkg::MAC_CMD_RD_BIT]) begin
                            nxt_st.mac_data[dec.port] =
                                st_ff.mac[dec.port][st_ff.mac_idx[dec.port]];
                        end
                    end
                end
            end
        end
    end

    // State register; reset is handled in the next-state logic
    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    // Outputs straight from flip-flops
    assign bus_rdata = st_ff.rdata;
    assign mode_out  = st_ff.mode;

    // Per-port queue outputs
    genvar gp;
    generate
        for (gp = 0; gp < hsdc_pkg::PORTS; gp++) begin : g_port
            assign qcfg_out[gp] = st_ff.q[gp];
        end
    endgenerate

endmodule : hsdc_top

`default_nettype wire

// ==== hsdc_top_bench.sv ====
`timescale 1ns/10ps
`default_nettype none

module hsdc_top_bench;
    logic                         clk;
    logic                         sys_rst = 1'b1;
    hsdc_pkg::hsdc_strap_t        strap_set = '0;  // Bench choice of straps
    hsdc_pkg::hsdc_strap_t        straps;          // Pins from the board model
    hsdc_pkg::hsdc_bus_t          bus_req = '0;
    logic [7:0]                   bus_rdata;
    hsdc_pkg::hsdc_mode_t         mode_out;
    hsdc_pkg::hsdc_qcfg_t [3:0]   qcfg_out;
    logic [7:0]                   exp_q[$];        // Expected read data, oldest first
    logic                         rd_seen = 1'b0;  // Read issued one edge ago
    int                           fails = 0;
    int                           checked = 0;
    integer                       seed = 32'h6fbf6989;

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    hsdc_strap_board u_board (.clk(clk), .setting(strap_set), .straps(straps));
    hsdc_top DUT (.clk(clk), .sys_rst(sys_rst), .straps(straps), .bus_req(bus_req),
                  .bus_rdata(bus_rdata), .mode_out(mode_out), .qcfg_out(qcfg_out));

    task automatic chk_rd(input string what, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk_rd
    task automatic chk_cnt(input string what, input logic [10:0] e, input logic [10:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %0d seen %0d", what, e, g);
        end
    endtask : chk_cnt
    task automatic chk_mode(input hsdc_pkg::hsdc_mode_t e, input hsdc_pkg::hsdc_mode_t g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR mode expected %h seen %h", e, g);
        end
    endtask : chk_mode

    // Read data lands one edge after the read; check it at the next edge
    always @(posedge clk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("ERROR read data expected none seen %h", bus_rdata);
            end else begin
                chk_rd("read data", exp_q.pop_front(), bus_rdata);
            end
        end
        rd_seen <= bus_req.rd;
    end

    // One bus cycle; expected data noted when a read is launched
    task automatic op(input logic [9:0] a, input logic [7:0] d, input logic w,
                      input logic r, input logic [7:0] e);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
        if (r) exp_q.push_back(e);
    endtask : op
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            bus_req <= '0;
        end
    endtask : idle

    // Straps held through a 16-cycle reset, then let modes settle
    task automatic do_reset(input hsdc_pkg::hsdc_strap_t s);
        @(posedge clk);
        strap_set <= s;
        sys_rst <= 1'b1;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : do_reset

    // Default count k (struct field order) for profile pr, port index p
    function automatic logic [10:0] exp_cnt(input int k, input logic [1:0] pr, input int p);
        logic [10:0] t [6];
        t = '{11'd640, 11'd384, 11'd192, 11'd1408, 11'd960, 11'd480};
        if (pr == 2'h1 && p < 3) begin
            t[0] = 11'd512;
            t[3] = 11'd1536;
        end
        if (pr == 2'h1) begin
            t[4] = 11'd1024;
            t[5] = 11'd512;
        end
        if (pr == 2'h2 && p < 2) begin
            t = '{11'd768, 11'd384, 11'd192, 11'd1280, 11'd768, 11'd384};
        end
        return t[k];
    endfunction : exp_cnt

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        $display("ERROR watchdog expected finish seen timeout");
        tally_and_finish();
    end

    initial begin
        hsdc_pkg::hsdc_strap_t s;
        hsdc_pkg::hsdc_mode_t  em;
        logic [10:0]           x;
        // Every profile, random other straps, last case with hardware mode off
        for (int c = 0; c < 8; c++) begin
            s = hsdc_pkg::hsdc_strap_t'($random(seed));
            s.strap_config_enable = (c != 7);
            s.profile_select = c[1:0];
            do_reset(s);
            em = '0;
            if (s.strap_config_enable) em = {1'b1, s.reduced_interface_select,
                s.serial_role_select, s.port_duplex_select, s.laps_encap_enable,
                ~s.scrambler_disable, s.bit_order_reverse};
            chk_mode(em, mode_out);
            for (int p = 0; p < 4; p++) begin
                for (int k = 0; k < 6; k++) begin
                    x = s.strap_config_enable ? exp_cnt(k, c[1:0], p) : 11'h000;
                    chk_cnt("queue count", x, qcfg_out[p][65-11*k -: 11]);
                end
            end
            for (int i = 0; i < 8; i++) begin
                x = s.strap_config_enable ? exp_cnt(i[0] ? 0 : 3, c[1:0], i / 2) : 11'h000;
                op(10'h040 + 10'(i), 8'h00, 1'b0, 1'b1, x[10:3]);
            end
            if (s.strap_config_enable) op(10'h030, 8'h00, 1'b0, 1'b1, {1'b1, c[1:0],
                s.reduced_interface_select, s.serial_role_select, s.laps_encap_enable,
                ~s.scrambler_disable, s.bit_order_reverse});
            idle(2);
            $display("profile case %0d done", c);
        end
        // Reserved access, latched status, queue write, indirect MAC access
        s.strap_config_enable = 1'b1;
        s.profile_select = 2'h0;
        do_reset(s);
        op(10'h3c0, 8'h00, 1'b1, 1'b0, 8'h00);
        op(10'h048, 8'h00, 1'b0, 1'b1, 8'h00);
        op(10'h080, 8'h00, 1'b0, 1'b1, 8'h00);
        op(10'h031, 8'h00, 1'b0, 1'b1, 8'h02);
        op(10'h031, 8'h00, 1'b0, 1'b1, 8'h00);
        op(10'h041, 8'h60, 1'b1, 1'b0, 8'h00);
        op(10'h041, 8'h00, 1'b0, 1'b1, 8'h60);
        op(10'h140, 8'h03, 1'b1, 1'b0, 8'h00);
        op(10'h141, 8'ha5, 1'b1, 1'b0, 8'h00);
        op(10'h142, 8'h01, 1'b1, 1'b0, 8'h00);
        op(10'h141, 8'h00, 1'b1, 1'b0, 8'h00);
        op(10'h142, 8'h02, 1'b1, 1'b0, 8'h00);
        op(10'h141, 8'h00, 1'b0, 1'b1, 8'ha5);
        idle(2);
        chk_cnt("port 1 transmit size", 11'd768, qcfg_out[0].tx_queue_size);
        $display("register case done");
        // Strap wiggle after reset: modes hold, change is latched
        em = mode_out;
        strap_set <= s ^ 12'h008;
        idle(6);
        strap_set <= s;
        idle(6);
        chk_mode(em, mode_out);
        op(10'h031, 8'h00, 1'b0, 1'b1, 8'h01);
        op(10'h031, 8'h00, 1'b0, 1'b1, 8'h00);
        idle(3);
        $display("strap change case done");
        tally_and_finish();
    end
endmodule : hsdc_top_bench

bind hsdc_top hsdc_top_sva u_sva (.clk(clk), .sys_rst(sys_rst), .straps(straps),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .mode_out(mode_out), .qcfg_out(qcfg_out));

`default_nettype wire

// ==== hsdc_top_sva.sv ====
`timescale 1ns/10ps
`default_nettype none

// Port checker for the strap configuration block
module hsdc_top_sva (
    // Clock and reset
    input wire logic                                    clk,
    input wire logic                                    sys_rst,
    // Straps and register port
    input wire hsdc_pkg::hsdc_strap_t                   straps,
    input wire hsdc_pkg::hsdc_bus_t                     bus_req,
    input wire logic [hsdc_pkg::DATA_W-1:0]             bus_rdata,
    // Configuration outputs
    input wire hsdc_pkg::hsdc_mode_t                    mode_out,
    input wire hsdc_pkg::hsdc_qcfg_t [hsdc_pkg::PORTS-1:0] qcfg_out
);
    // One clock domain only
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Host may rewrite queue sizes; default checks stop after such a write
    logic q_wr_seen;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q_wr_seen <= 1'b0;
        end else if (bus_req.wr && bus_req.addr >= 10'h040 && bus_req.addr <= 10'h047) begin
            q_wr_seen <= 1'b1;
        end
    end

    // Read data stands only in the cycle after a read
    property p_rdata_idle;
        !$past(bus_req.rd) |-> bus_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
    // Modes all zero while hardware mode is off
    property p_mode_off;
        !mode_out.hw_mode_active |-> mode_out == '0;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("mode set while off");
    // Queue values zero while hardware mode is off; skip first edge after release
    property p_q_off;
        !$past(sys_rst) && !q_wr_seen && !mode_out.hw_mode_active |-> qcfg_out == '0;
    endproperty
    a_q_off: assert property (p_q_off) else $error("queue value while off");
    // Two settled cycles out of reset, modes never move
    property p_mode_hold;
        !$past(sys_rst, 2) && !$past(sys_rst) |-> $stable(mode_out);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
    // Reserved and BERT space read as zero
    property p_rd_rsvd;
        bus_req.rd && (bus_req.addr >= 10'h3c0 || (bus_req.addr >= 10'h080
            && bus_req.addr <= 10'h0bf)) |=> bus_rdata == 8'h00;
    endproperty
    a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved read not zero");
    // Strap status mirrors the live modes
    property p_stat;
        bus_req.rd && bus_req.addr == 10'h030 && mode_out.hw_mode_active |=> bus_rdata[7]
            && bus_rdata[4:0] == {mode_out.rmii_mode, mode_out.serial_is_dce,
            mode_out.laps_enable, mode_out.scrambler_enable, mode_out.lsb_first};
    endproperty
    a_stat: assert property (p_stat) else $error("strap status wrong");
    // Port 4 transmit size register in steps of eight buffers
    property p_qreg;
        bus_req.rd && bus_req.addr == 10'h047 |=>
            bus_rdata == $past(qcfg_out[3].tx_queue_size[10:3]);
    endproperty
    a_qreg: assert property (p_qreg) else $error("queue size register wrong");
    // Port 4 receive size is the same in every profile
    property p_rx4;
        mode_out.hw_mode_active && !q_wr_seen |-> qcfg_out[3].rx_queue_size == 11'd1408;
    endproperty
    a_rx4: assert property (p_rx4) else $error("port 4 receive size wrong");
    // Transmit marks fixed on every port
    for (genvar p = 0; p < 4; p++) begin : g_port
        property p_tx_marks;
            mode_out.hw_mode_active |-> qcfg_out[p].tx_queue_high_mark == 11'd384
                && qcfg_out[p].tx_queue_low_mark == 11'd192;
        endproperty
        a_tx_marks: assert property (p_tx_marks) else $error("transmit mark wrong");
    end
endmodule : hsdc_top_sva

`default_nettype wire
